// file: hw/quad_dac_update_control.sv
// Purpose: command decode and update control of a four channel dac
// Assumes: frames arrive whole from the serial slave on clk; pins are asynchronous
// Notes: rst_n is the power-on reset; hw_reset_n is the device reset pin

`timescale 1ns/1ps

module quad_dac_update_control
  import quad_dac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic frame_valid,
  input wire logic [FRAME_BITS-1:0] frame_data,
  input wire logic load_strobe_n,
  input wire logic hw_reset_n,
  input wire logic power_up_level_select,
  output logic [CHANNELS*DAC_BITS-1:0] dac_values,
  output logic [3:0] load_hold_mask,
  output logic reference_disable,
  output logic init_done
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  typedef enum logic [0:0] {st_init, st_run} state_e;

  state_e state; // init until pins settle
  state_e next_state;
  logic [1:0] settle; // cycles since power-on reset
  logic [1:0] next_settle;
  logic [3:0] next_mask;
  logic next_ref;

  logic [2:0] ld_sync; // strobe pin, [0] first stage
  logic [2:0] rs_sync; // reset pin
  logic [2:0] sel_sync; // level select pin
  logic [2:0] next_ld_sync;
  logic [2:0] next_rs_sync;
  logic [2:0] next_sel_sync;
  logic ld_level; // accepted strobe level
  logic rs_level; // accepted reset pin level, low = reset
  logic sel_level; // accepted select level
  logic next_ld_level;
  logic next_rs_level;
  logic next_sel_level;
  logic ld_fall; // accepted falling edge of the strobe

  cmd_t cmd; // frame fields
  logic [3:0] addr;
  code_t frame_code;

  logic [CHANNELS-1:0] do_load_input; // per channel controls
  logic [CHANNELS-1:0] do_load_dac;
  logic [CHANNELS-1:0] do_copy;
  logic do_clear;
  code_t clear_code;
  code_t in_vals [CHANNELS]; // observed register contents
  code_t dac_vals [CHANNELS];

  chan_if cif [CHANNELS] ();

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  // a level counts once stages two and three agree; stage one feeds only stage two
  always_comb
  begin
    next_ld_sync = {ld_sync[1:0], load_strobe_n};
    next_rs_sync = {rs_sync[1:0], hw_reset_n};
    next_sel_sync = {sel_sync[1:0], power_up_level_select};
    next_ld_level = (ld_sync[1] == ld_sync[2]) ? ld_sync[2] : ld_level;
    next_rs_level = (rs_sync[1] == rs_sync[2]) ? rs_sync[2] : rs_level;
    next_sel_level = (sel_sync[1] == sel_sync[2]) ? sel_sync[2] : sel_level;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ld_sync <= 3'h7;
      rs_sync <= 3'h0;
      sel_sync <= 3'h0;
      ld_level <= 1'b1;
      rs_level <= 1'b0; // treat the device as held in reset until seen
      sel_level <= 1'b0;
    end
    else
    begin
      ld_sync <= next_ld_sync;
      rs_sync <= next_rs_sync;
      sel_sync <= next_sel_sync;
      ld_level <= next_ld_level;
      rs_level <= next_rs_level;
      sel_level <= next_sel_level;
    end
  end

  // edge taken from the accepted level, so a glitch shorter than a cycle never fires
  assign ld_fall = ld_level && !next_ld_level;

  // ***************************************************************
  // frame fields
  // ***************************************************************
  assign cmd = frame_data[CMD_MSB:CMD_LSB];
  assign addr = frame_data[ADDR_MSB:ADDR_LSB];
  assign frame_code = frame_data[DATA_MSB:DATA_LSB];
  assign clear_code = sel_level ? MID_SCALE_CODE : ZERO_SCALE_CODE;

  // ***************************************************************
  // control next state
  // ***************************************************************
  always_comb
  begin
    next_state = state;
    next_settle = settle;
    next_mask = load_hold_mask;
    next_ref = reference_disable;
    do_load_input = '0;
    do_load_dac = '0;
    do_copy = '0;
    do_clear = 1'b0;
    unique case (state)
      st_init:
      begin
        // strobe activity is not looked at here at all
        if (settle != SETTLE_CYCLES)
        begin
          next_settle = settle + 2'h1;
        end
        else if (rs_level)
        begin
          do_clear = 1'b1;
          next_state = st_run;
        end
      end
      st_run:
      begin
        if (!rs_level)
        begin
          // outputs held at the clear code, frames dropped meanwhile
          do_clear = 1'b1;
        end
        else
        begin
          // masked channels ignore the falling edge of the strobe
          if (ld_fall)
          begin
            do_copy = ~load_hold_mask;
          end
          if (frame_valid)
          begin
            case (cmd)
              CMD_WRITE_INPUT:
              begin
                do_load_input = addr;
                // strobe low: mask deliberately not applied
                if (!ld_level)
                begin
                  do_load_dac = addr;
                end
              end
              CMD_UPDATE_DAC:
              begin
                do_copy = do_copy | addr;
              end
              CMD_WRITE_UPDATE:
              begin
                do_load_input = addr;
                do_load_dac = addr;
              end
              CMD_LOAD_MASK:
              begin
                next_mask = frame_data[MASK_MSB:MASK_LSB];
              end
              CMD_SOFT_RESET:
              begin
                do_clear = 1'b1;
                next_mask = MASK_RESET;
                next_ref = REF_DISABLE_RESET;
              end
              CMD_REF_SETUP:
              begin
                next_ref = frame_data[REF_BIT];
              end
              default:
              begin
                // other commands belong to blocks outside this one
              end
            endcase
          end
        end
      end
    endcase
  end

  // ***************************************************************
  // control registers
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= st_init;
      settle <= 2'h0;
      load_hold_mask <= MASK_RESET;
      reference_disable <= REF_DISABLE_RESET;
    end
    else
    begin
      state <= next_state;
      settle <= next_settle;
      load_hold_mask <= next_mask;
      reference_disable <= next_ref;
    end
  end

  assign init_done = (state == st_run);

  // ***************************************************************
  // channels
  // ***************************************************************
  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_chan
    assign cif[i].load_input = do_load_input[i];
    assign cif[i].load_dac = do_load_dac[i];
    assign cif[i].copy_to_dac = do_copy[i];
    assign cif[i].clear = do_clear;
    assign cif[i].data = frame_code;
    assign cif[i].clear_code = clear_code;
    assign in_vals[i] = cif[i].input_value;
    assign dac_vals[i] = cif[i].dac_value;
    assign dac_values[i*DAC_BITS +: DAC_BITS] = cif[i].dac_value;

    dac_channel u_chan
    (
      .clk(clk),
      .rst_n(rst_n),
      .port(cif[i])
    );
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  localparam int RST_WIN = RESET_MIN_CYC; // bound on reaction to the reset pin
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic live; // running and not held by the reset pin
  assign live = (state == st_run) && rs_level;

  sequence s_strobe_fall;
    live && ld_fall && !frame_valid;
  endsequence

  sequence s_pin_reset;
    (state == st_run) && !rs_level;
  endsequence

  a_write_low: assert property ((live && frame_valid && cmd == CMD_WRITE_INPUT && addr[1]
    && !ld_level) |=> (dac_vals[1] == $past(frame_code)) && (in_vals[1] == $past(frame_code)))
    else $error("strobe low write missed dac register");

  a_write_held: assert property ((live && frame_valid && cmd == CMD_WRITE_INPUT && addr[0]
    && ld_level && !ld_fall) |=> (dac_vals[0] == $past(dac_vals[0]))
    && (in_vals[0] == $past(frame_code)))
    else $error("strobe high write changed dac register");

  a_strobe_update: assert property ((s_strobe_fall ##0 !load_hold_mask[3])
    |=> dac_vals[3] == $past(in_vals[3]))
    else $error("strobe fall did not update channel d");

  a_masked_ignore: assert property ((s_strobe_fall ##0 load_hold_mask[0])
    |=> dac_vals[0] == $past(dac_vals[0]))
    else $error("masked channel followed the strobe");

  a_mask_load: assert property ((live && frame_valid && cmd == CMD_LOAD_MASK)
    |=> load_hold_mask == $past(frame_data[MASK_MSB:MASK_LSB]))
    else $error("mask not loaded from frame");

  a_mask_reset: assert property (disable iff (1'b0) !rst_n |=> load_hold_mask == MASK_RESET
    && reference_disable == REF_DISABLE_RESET)
    else $error("mask or reference bit not reset");

  a_copy_cmd: assert property ((live && frame_valid && cmd == CMD_UPDATE_DAC && addr[0])
    |=> (dac_vals[0] == $past(in_vals[0])) && (in_vals[0] == $past(in_vals[0])))
    else $error("copy command wrong");

  a_write_both: assert property ((live && frame_valid && cmd == CMD_WRITE_UPDATE && addr[3])
    |=> (dac_vals[3] == $past(frame_code)) && (in_vals[3] == $past(frame_code)))
    else $error("write and update wrong");

  a_pin_clear: assert property ($fell(rs_level) && state == st_run
    |-> ##[1:RST_WIN] dac_vals[1] == clear_code)
    else $error("reset pin did not clear outputs");

  a_pin_refuse: assert property (s_pin_reset ##1 s_pin_reset
    |-> dac_vals[2] == $past(clear_code) && in_vals[2] == $past(clear_code))
    else $error("update accepted under reset pin");

  a_soft_reset: assert property ((live && frame_valid && cmd == CMD_SOFT_RESET)
    |=> dac_vals[0] == $past(clear_code) && load_hold_mask == MASK_RESET)
    else $error("soft reset did not restore code");

  a_init_quiet: assert property ((state == st_init) ##1 (state == st_init)
    |-> dac_vals[3] == CHANNEL_RESET)
    else $error("output moved during init");

  a_init_wait: assert property ((state == st_init && !rs_level) |=> state == st_init)
    else $error("init left while reset pin low");

  a_power_level: assert property ($rose(init_done) |-> dac_vals[2] == $past(clear_code))
    else $error("power-up level wrong");

  a_ref_load: assert property ((live && frame_valid && cmd == CMD_REF_SETUP)
    |=> reference_disable == $past(frame_data[REF_BIT]))
    else $error("reference bit not loaded");
endmodule

// file: hw/quad_dac_pkg.sv
// Purpose: shared constants and types for the quad dac update control
// Assumes: 24-bit command frames, 10-bit codes left justified in the data field
// Notes: every offset, field position and timing count lives here, with the channel, mask and reference reset values

package quad_dac_pkg;

  // ***************************************************************
  // sizes
  // ***************************************************************
  localparam int CHANNELS = 4; // channels a, b, c, d
  localparam int DAC_BITS = 10; // code width per channel
  localparam int FRAME_BITS = 24; // three bytes per write

  // ***************************************************************
  // frame field positions
  // ***************************************************************
  localparam int CMD_MSB = 23; // command code top bit
  localparam int CMD_LSB = 20; // command code low bit
  localparam int ADDR_MSB = 19; // channel select, d
  localparam int ADDR_LSB = 16; // channel select, a
  localparam int DATA_MSB = 15; // code msb
  localparam int DATA_LSB = 6; // code lsb, low bits unused
  localparam int MASK_MSB = 3; // load mask, channel d
  localparam int MASK_LSB = 0; // load mask, channel a
  localparam int REF_BIT = 0; // reference off bit

  // ***************************************************************
  // command codes
  // ***************************************************************
  typedef logic [3:0] cmd_t;
  localparam cmd_t CMD_WRITE_INPUT = 4'h1; // input register, strobe dependent
  localparam cmd_t CMD_UPDATE_DAC = 4'h2; // copy input to dac register
  localparam cmd_t CMD_WRITE_UPDATE = 4'h3; // write both registers
  localparam cmd_t CMD_LOAD_MASK = 4'h5; // load hold mask
  localparam cmd_t CMD_SOFT_RESET = 4'h6; // back to power-on code
  localparam cmd_t CMD_REF_SETUP = 4'h7; // internal reference on/off

  // ***************************************************************
  // codes and reset values
  // ***************************************************************
  typedef logic [DAC_BITS-1:0] code_t;
  localparam code_t ZERO_SCALE_CODE = 10'h000; // select pin low
  localparam code_t MID_SCALE_CODE = 10'h200; // select pin high
  localparam code_t CHANNEL_RESET = 10'h000; // before init completes
  localparam logic [3:0] MASK_RESET = 4'h0; // every channel follows strobe
  localparam logic REF_DISABLE_RESET = 1'b0; // reference on

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_PS = 5000; // 200 MHz
  localparam int RESET_MIN_NS = 30; // least hold of the reset pin
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3; // synchroniser fill after power-up

endpackage

// file: hw/chan_if.sv
// Purpose: control and value lines between the controller and one channel
// Assumes: one instance per channel, same clock on both ends
// Notes: clear wins over every load in the channel

`timescale 1ns/1ps

interface chan_if;
  import quad_dac_pkg::*;
  logic load_input; // take data into input register
  logic load_dac; // take data into dac register
  logic copy_to_dac; // move input register to dac register
  logic clear; // both registers to clear_code
  code_t data; // code from the frame
  code_t clear_code; // zero or midscale
  code_t input_value; // input register contents
  code_t dac_value; // dac register contents

  modport ctrl
  (
    output load_input,
    output load_dac,
    output copy_to_dac,
    output clear,
    output data,
    output clear_code,
    input input_value,
    input dac_value
  );

  modport chan
  (
    input load_input,
    input load_dac,
    input copy_to_dac,
    input clear,
    input data,
    input clear_code,
    output input_value,
    output dac_value
  );
endinterface

// file: hw/dac_channel.sv
// Purpose: input register and dac register of one channel
// Assumes: controller may raise load_dac and copy_to_dac in one cycle
// Notes: a direct data load beats a copy, clear beats both

`timescale 1ns/1ps

module dac_channel
  import quad_dac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  chan_if.chan port
);

  code_t input_reg; // staged code
  code_t dac_reg; // code that drives the output
  code_t next_input_reg;
  code_t next_dac_reg;

  // ***************************************************************
  // next values
  // ***************************************************************
  always_comb
  begin
    next_input_reg = input_reg;
    next_dac_reg = dac_reg;
    if (port.clear)
    begin
      // pin reset, soft reset or end of init; rst_n is taken in the registers
      next_input_reg = port.clear_code;
      next_dac_reg = port.clear_code;
    end
    else
    begin
      if (port.load_input)
      begin
        next_input_reg = port.data;
      end
      if (port.load_dac)
      begin
        // direct write, uses frame data not the old input value
        next_dac_reg = port.data;
      end
      else if (port.copy_to_dac)
      begin
        next_dac_reg = input_reg;
      end
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      input_reg <= CHANNEL_RESET;
      dac_reg <= CHANNEL_RESET;
    end
    else
    begin
      input_reg <= next_input_reg;
      dac_reg <= next_dac_reg;
    end
  end

  assign port.input_value = input_reg;
  assign port.dac_value = dac_reg;

endmodule

// file: tb/frame_master.sv
// Purpose: stand-in for the bus master that hands whole frames to the block
// Assumes: frames are already assembled from the three serial bytes
// Notes: drives only at the falling edge; a released bus shows inverted data

`timescale 1ns/1ps

module frame_master
  import quad_dac_pkg::*;
(
  input wire logic clk,
  output logic frame_valid,
  output logic [FRAME_BITS-1:0] frame_data
);
  // idle bus at time zero
  initial
  begin
    frame_valid = 1'b0;
    frame_data = 24'h000000;
  end

  // ***************************************************************
  // one frame: command, channel select, then data
  // ***************************************************************
  // gap lets a slow master idle first; zero still leaves one idle cycle between frames
  task automatic send(input logic [FRAME_BITS-1:0] word, input int gap);
    repeat (gap) @(negedge clk);
    @(negedge clk);
    frame_valid = 1'b1;
    frame_data = word;
    @(negedge clk);
    frame_valid = 1'b0;
    // stale data would hide a decode that samples late
    frame_data = ~word;
  endtask
endmodule

// file: tb/quad_dac_update_control_tb_top.sv
// Purpose: self-checking bench for the quad dac update control
// Assumes: outputs settle within two cycles of a frame and six of a pin edge
// Notes: table rows carry pin level, frame and expected registers

`timescale 1ns/1ps

module quad_dac_update_control_tb_top
  import quad_dac_pkg::*;
;
  // ***************************************************************
  // signals and bookkeeping
  // ***************************************************************
  typedef struct {
    logic strobe_n; // pin level for the row
    logic [23:0] frame; // frame sent in the row
    logic [39:0] dac; // channel d..a codes
    logic [3:0] mask; // expected hold mask
    logic ref_off; // expected reference bit
  } row_s;
  logic clk = 1'b0; // 200 MHz, low before any process runs
  logic rst_n; // power-on reset
  logic frame_valid; // from the master model
  logic [FRAME_BITS-1:0] frame_data; // from the master model
  logic load_strobe_n; // load pin
  logic hw_reset_n; // device reset pin
  logic power_up_level_select; // clear level pin
  logic [CHANNELS*DAC_BITS-1:0] dac_values; // register codes
  logic [3:0] load_hold_mask; // mask register
  logic reference_disable; // reference off
  logic init_done; // init finished
  int n_errors; // mismatches
  int n_tests; // comparisons
  int cycles; // timeout counter
  row_s rows[14]; // ordinary cases
  localparam code_t K = MID_SCALE_CODE; // midscale shorthand

  // ***************************************************************
  // design and master model
  // ***************************************************************
  quad_dac_update_control i_quad_dac_update_control
  (
    .clk(clk),
    .rst_n(rst_n),
    .frame_valid(frame_valid),
    .frame_data(frame_data),
    .load_strobe_n(load_strobe_n),
    .hw_reset_n(hw_reset_n),
    .power_up_level_select(power_up_level_select),
    .dac_values(dac_values),
    .load_hold_mask(load_hold_mask),
    .reference_disable(reference_disable),
    .init_done(init_done)
  );

  frame_master i_frame_master
  (
    .clk(clk),
    .frame_valid(frame_valid),
    .frame_data(frame_data)
  );

  // ***************************************************************
  // helpers
  // ***************************************************************
  // code frame: data left justified, low six bits unused
  function automatic logic [23:0] fw(input cmd_t c, input logic [3:0] a, input logic [9:0] d);
    return {c, a, d, 6'h00};
  endfunction

  // control frame: low nibble carries mask or reference bit
  function automatic logic [23:0] fc(input cmd_t c, input logic [3:0] low);
    return {c, 4'hF, 12'h000, low};
  endfunction

  // compare and count; mismatch printed at once
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // mask and reference together
  task automatic chk_ctl(input logic [3:0] m, input logic r);
    chk(40'({load_hold_mask, reference_disable}), 40'({m, r}));
  endtask

  // pin level change, then long enough for sync and re-arm
  task automatic pin(input logic lvl);
    @(negedge clk);
    load_strobe_n = lvl;
    repeat (8) @(negedge clk);
  endtask

  // frame then two settle cycles
  task automatic frame(input logic [23:0] w);
    i_frame_master.send(w, 0);
    repeat (2) @(negedge clk);
  endtask

  // verdict, one place only
  task automatic end_of_test();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ***************************************************************
  // clock and timeout
  // ***************************************************************
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // whole run is well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    n_errors = 0;
    n_tests = 0;
    rst_n = 1'b0;
    hw_reset_n = 1'b0;
    load_strobe_n = 1'b1;
    power_up_level_select = 1'b1;
    // rows: pin, frame, codes d c b a, mask, reference
    rows[0] = '{1'b1, fw(CMD_WRITE_INPUT, 4'h1, 10'h155), {K, K, K, K}, 4'h0, 1'b0};
    rows[1] = '{1'b1, fw(CMD_WRITE_INPUT, 4'h6, 10'h0AA), {K, K, K, K}, 4'h0, 1'b0};
    rows[2] = '{1'b1, fw(CMD_UPDATE_DAC, 4'h1, 10'h3C3), {K, K, K, 10'h155}, 4'h0, 1'b0};
    rows[3] = '{1'b1, fw(CMD_WRITE_UPDATE, 4'h8, 10'h3FF), {10'h3FF, K, K, 10'h155}, 4'h0, 1'b0};
    rows[4] = '{1'b1, fc(CMD_LOAD_MASK, 4'h5), {10'h3FF, K, K, 10'h155}, 4'h5, 1'b0};
    rows[5] = '{1'b1, fc(CMD_REF_SETUP, 4'h1), {10'h3FF, K, K, 10'h155}, 4'h5, 1'b1};
    rows[6] = '{1'b1, fc(CMD_REF_SETUP, 4'h0), {10'h3FF, K, K, 10'h155}, 4'h5, 1'b0};
    rows[7] = '{1'b1, fw(4'h4, 4'h1, 10'h001), {10'h3FF, K, K, 10'h155}, 4'h5, 1'b0};
    rows[8] = '{1'b0, fw(CMD_WRITE_INPUT, 4'h2, 10'h123), {10'h3FF, K, 10'h123, 10'h155}, 4'h5, 1'b0};
    rows[9] = '{1'b0, fw(CMD_WRITE_INPUT, 4'h4, 10'h321), {10'h3FF, 10'h321, 10'h123, 10'h155}, 4'h5, 1'b0};
    rows[10] = '{1'b1, fw(CMD_WRITE_INPUT, 4'h1, 10'h00F), {10'h3FF, 10'h321, 10'h123, 10'h155}, 4'h5, 1'b0};
    rows[11] = '{1'b0, fc(CMD_LOAD_MASK, 4'h0), {10'h3FF, 10'h321, 10'h123, 10'h155}, 4'h0, 1'b0};
    rows[12] = '{1'b1, fw(4'h0, 4'hF, 10'h3FF), {10'h3FF, 10'h321, 10'h123, 10'h155}, 4'h0, 1'b0};
    rows[13] = '{1'b0, fw(4'hF, 4'hF, 10'h000), {10'h3FF, 10'h321, 10'h123, 10'h00F}, 4'h0, 1'b0};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    // pin held low at power-up, strobe pulsed meanwhile
    pin(1'b0);
    pin(1'b1);
    chk(40'(init_done), 40'h0);
    hw_reset_n = 1'b1;
    repeat (30)
    begin
      @(negedge clk);
      if (init_done === 1'b1)
        break;
    end
    chk(40'(init_done), 40'h1);
    chk(dac_values, {K, K, K, K});
    chk_ctl(4'h0, 1'b0);
    // ordinary cases
    foreach (rows[i])
    begin
      if (load_strobe_n !== rows[i].strobe_n)
        pin(rows[i].strobe_n);
      frame(rows[i].frame);
      chk(dac_values, rows[i].dac);
      chk_ctl(rows[i].mask, rows[i].ref_off);
    end
    // device reset pin to zero scale, frames and strobe refused
    pin(1'b1);
    power_up_level_select = 1'b0;
    @(negedge clk);
    hw_reset_n = 1'b0;
    repeat (RESET_MIN_CYC + 2) @(negedge clk);
    chk(dac_values, 40'h0);
    frame(fw(CMD_WRITE_UPDATE, 4'h2, 10'h222));
    pin(1'b0);
    pin(1'b1);
    chk(dac_values, 40'h0);
    hw_reset_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(dac_values, 40'h0);
    pin(1'b0);
    pin(1'b1);
    chk(dac_values, 40'h0);
    frame(fw(CMD_WRITE_UPDATE, 4'h1, 10'h111));
    chk(dac_values, {30'h0, 10'h111});
    // soft reset back to the power-on code at midscale
    power_up_level_select = 1'b1;
    frame(fc(CMD_REF_SETUP, 4'h1));
    frame(fc(CMD_LOAD_MASK, 4'hF));
    chk_ctl(4'hF, 1'b1);
    frame(fc(CMD_SOFT_RESET, 4'h0));
    chk(dac_values, {K, K, K, K});
    chk_ctl(4'h0, 1'b0);
    end_of_test();
  end
endmodule
